// ---- sram_array_model.sv ----
// Behavioural array port partner: read data source and write logger
`timescale 1ns/1ns
module sram_array_model
  import sram_cycle_pkg::*;
(
  // Clock and stall control
  input wire logic ref_clk,
  input wire logic hold,
  // Read side
  input wire logic [sram_cycle_pkg::ADDR_W-1:0] rd_addr,
  input wire logic rd_en,
  output logic [sram_cycle_pkg::DATA_W-1:0] rdata,
  // Write side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [sram_cycle_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [sram_cycle_pkg::DATA_W-1:0] wdata,
  input wire logic [sram_cycle_pkg::LANES-1:0] wr_lanes
);
  import sram_cycle_pkg::*;
  logic [ADDR_W-1:0] noise = 17'h0;
  logic [ADDR_W-1:0] log_a[$];
  logic [DATA_W-1:0] log_d[$];
  logic [LANES-1:0] log_l[$];
  // Outside a read the bus sits at zero with bit 0 clear, so stale data never matches
  always_comb rdata = rd_en ? {rd_addr, 1'b1} : {noise, 1'b0};
  assign wr_ready = !hold;
  always @(posedge ref_clk) begin
    noise <= ~noise + 17'h1;
    if (wr_valid && wr_ready) begin
      log_a.push_back(wr_addr);
      log_d.push_back(wdata);
      log_l.push_back(wr_lanes);
    end
  end
endmodule

// ---- sram_burst_addr.sv ----
// Address register and 2-bit burst counter
`timescale 1ns/1ns
module sram_burst_addr
  import sram_cycle_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic advance,
  input wire logic interleave,
  input wire logic [sram_cycle_pkg::ADDR_W-1:0] ext_addr,
  // Address out
  output logic [sram_cycle_pkg::ADDR_W-1:0] cur_addr
);
  logic [ADDR_W-1:0] base_q, base_d;
  logic [BURST_W-1:0] step_q, step_d;

  always_comb begin
    base_d = base_q;
    step_d = step_q;
    if (load) begin
      base_d = ext_addr;
      step_d = BURST_RST;
    end else if (advance) begin
      step_d = step_q + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      base_q <= ADDR_RST;
      step_q <= BURST_RST;
    end else begin
      base_q <= base_d;
      step_q <= step_d;
    end
  end

  // Shows the address this edge uses, so the caller registers it directly
  // Step zero is the seed itself; others follow the chosen order
  assign cur_addr = {base_d[ADDR_W-1:BURST_W],
    (step_d == BURST_RST) ? base_d[BURST_W-1:0] :
    next_burst(base_d[BURST_W-1:0], step_d - 2'h1, interleave)};
endmodule

// ---- sram_cycle_pkg.sv ----
// Package with cycle decode constants for the burst SRAM controller
package sram_cycle_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 16;
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [LANES-1:0] LANE_NONE = 2'h0;
  localparam logic [LANES-1:0] LANE_ALL = 2'h3;
  // Sleep entry is immediate; exit takes two clocks
  localparam int SLEEP_SYNC_CYCLES = 2;

  typedef enum logic [4:0] {
    CYC_IDLE = 5'b00001,
    CYC_READ = 5'b00010,
    CYC_WRITE = 5'b00100,
    CYC_SLEEP = 5'b01000,
    CYC_DESEL = 5'b10000
  } cycle_t;

  function automatic logic [BURST_W-1:0] next_burst(input logic [BURST_W-1:0] base,
                                                     input logic [BURST_W-1:0] step,
                                                     input logic interleave);
    logic [BURST_W-1:0] s;
    s = step + 2'h1;
    return interleave ? (base ^ s) : (base + s);
  endfunction
endpackage

// ---- sram_wr_fifo.sv ----
// Write data FIFO between bus capture and array port
`timescale 1ns/1ns
module sram_wr_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; only pointers and count need a defined value
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rp_q];
endmodule

// ---- sync_burst_sram_cycle_ctrl.sv ----
// Cycle decode, burst control and data bus steering for the burst SRAM
`timescale 1ns/1ns
// How it works
// - Any chip select inactive with a strobe taken: deselect, no address, bus floats.
// - Selected, awake, processor strobe low: start read at external address, writes ignored.
// - Selected, controller strobe only, write requested: begin write at external address.
// - Selected, controller strobe only, no write: begin read, drive only when enabled.
// - No start and advance low: continue read at next counter address.
// - No start, advance low, write requested: write at next counter address.
// - No start and advance high: hold counter, read current address again.
// - No start, advance high, write requested: write current unadvanced address.
// - Never accept a write in the cycle the processor strobe is sampled.
// - Read data registered; bus gated by the registered read flag and by output enable, the enable without clock sampling.
// - Controller strobe low captures all address bits and seeds counter.
// - Processor strobe low captures address and seeds counter from low bits.
// - Both strobes low: act on processor strobe, ignore controller strobe.
// - Processor strobe ignored while first active-low chip select is high.
// - Low two address bits seed counter and form part of location index.
// - Upper address sampled only when selected and a strobe is low.
// - Sleep high: standby, ignore inputs, keep contents, float bus.
// - Counter wraps linear when order select low, interleaved when high.
// - Global write writes all bytes; else lane enable plus per-lane selects.
module sync_burst_sram_cycle_ctrl
  import sram_cycle_pkg::*;
#(
  parameter int FIFO_DEPTH_P = sram_cycle_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus side control
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic chip_sel_low_a,
  input wire logic chip_sel_high,
  input wire logic chip_sel_low_b,
  input wire logic sleep_request,
  input wire logic burst_order_sel,
  input wire logic output_enable_n,
  input wire logic all_bytes_write_n,
  input wire logic lane_write_enable_n,
  input wire logic [sram_cycle_pkg::LANES-1:0] lane_select_n,
  input wire logic [sram_cycle_pkg::ADDR_W-1:0] addr,
  // Data bus, three signals per pin
  input wire logic [sram_cycle_pkg::DATA_W-1:0] data_in,
  output logic [sram_cycle_pkg::DATA_W-1:0] data_out,
  output logic [sram_cycle_pkg::DATA_W-1:0] data_oe_n,
  // Array port
  output logic [sram_cycle_pkg::ADDR_W-1:0] array_addr,
  output logic array_read,
  input wire logic [sram_cycle_pkg::DATA_W-1:0] array_rdata,
  output logic array_wr_valid,
  input wire logic array_wr_ready,
  output logic [sram_cycle_pkg::ADDR_W-1:0] array_wr_addr,
  output logic [sram_cycle_pkg::DATA_W-1:0] array_wdata,
  output logic [sram_cycle_pkg::LANES-1:0] array_wr_lanes,
  // Status
  output logic sleeping,
  output logic wr_stall
);
  import sram_cycle_pkg::*;

  localparam int FW = ADDR_W + DATA_W + LANES;

  cycle_t cyc_q, cyc_d;
  logic selected, proc_start, ctrl_start, any_start, wr_req, desel;
  logic load, advance, rd_now, wr_now;
  logic [LANES-1:0] lanes;
  logic [ADDR_W-1:0] cur_addr;
  logic [SLEEP_SYNC_CYCLES-1:0] sleep_sh_q, sleep_sh_d;
  logic asleep;
  logic [DATA_W-1:0] rdata_q, rdata_d, dout_q;
  logic drive_q, drive_d, oe_n_q;
  logic rd_q, rd_d;
  logic [ADDR_W-1:0] raddr_q, raddr_d;
  logic fifo_ready, fifo_vld;
  logic [FW-1:0] fifo_out;
  logic stall_q, stall_d;

  // Sleep takes effect at once and holds two clocks past release; it gates starts, advance and bus drive, not the write FIFO drain
  always_comb begin
    sleep_sh_d = {sleep_sh_q[SLEEP_SYNC_CYCLES-2:0], sleep_request};
  end
  assign asleep = sleep_sh_q[SLEEP_SYNC_CYCLES-1] || sleep_request;

  always_comb begin
    selected = !chip_sel_low_a && chip_sel_high && !chip_sel_low_b;
    // Processor strobe gated by first chip select and wins over controller strobe
    proc_start = !asleep && !processor_addr_strobe_n && !chip_sel_low_a;
    ctrl_start = !asleep && !controller_addr_strobe_n && processor_addr_strobe_n;
    any_start = proc_start || ctrl_start;
    desel = any_start && !selected;
    lanes = !all_bytes_write_n ? LANE_ALL :
            (!lane_write_enable_n ? ~lane_select_n : LANE_NONE);
    wr_req = lanes != LANE_NONE;
    load = any_start && selected;
    advance = !asleep && !any_start && !burst_advance_n
              && (cyc_q == CYC_READ || cyc_q == CYC_WRITE);
    rd_now = 1'b0;
    wr_now = 1'b0;
    cyc_d = cyc_q;
    if (asleep) begin
      cyc_d = CYC_SLEEP;
    end else if (desel) begin
      cyc_d = CYC_DESEL;
    end else if (proc_start) begin
      cyc_d = CYC_READ;
      rd_now = 1'b1;
    end else if (ctrl_start) begin
      cyc_d = wr_req ? CYC_WRITE : CYC_READ;
      wr_now = wr_req;
      rd_now = !wr_req;
    end else if (cyc_q == CYC_READ || cyc_q == CYC_WRITE) begin
      // Continue or suspend; advance picks next or current address
      cyc_d = wr_req ? CYC_WRITE : CYC_READ;
      wr_now = wr_req;
      rd_now = !wr_req;
    end else begin
      cyc_d = CYC_IDLE;
    end
  end

  sram_burst_addr u_addr (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(load),
    .advance(advance),
    .interleave(burst_order_sel),
    .ext_addr(addr),
    .cur_addr(cur_addr)
  );

  // Write data taken at the same edge as the address is registered
  logic wr_pend_q, wr_pend_d;
  logic [LANES-1:0] wr_lanes_q, wr_lanes_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;

  always_comb begin
    wr_pend_d = wr_now;
    wr_lanes_d = lanes;
    wr_addr_d = cur_addr;
    rd_d = rd_now;
    raddr_d = wr_addr_d;
    // Bus floats for a write regardless of output enable
    drive_d = rd_now;
    rdata_d = array_rdata;
    stall_d = wr_now && !fifo_ready;
  end

  // Counter already resolves load, advance and suspend for this edge
  logic [ADDR_W-1:0] eff_addr;
  assign eff_addr = cur_addr;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cyc_q <= CYC_IDLE;
      sleep_sh_q <= '0;
      rd_q <= 1'b0;
      raddr_q <= ADDR_RST;
      drive_q <= 1'b0;
      rdata_q <= '0;
      stall_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_lanes_q <= LANE_NONE;
      wr_addr_q <= ADDR_RST;
    end else begin
      cyc_q <= cyc_d;
      sleep_sh_q <= sleep_sh_d;
      rd_q <= rd_d;
      raddr_q <= raddr_d;
      drive_q <= drive_d;
      rdata_q <= rdata_d;
      stall_q <= stall_d;
      wr_pend_q <= wr_pend_d;
      wr_lanes_q <= wr_lanes_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  sram_wr_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH_P)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(wr_now),
    .in_ready(fifo_ready),
    .in_data({eff_addr, lanes, data_in}),
    .out_valid(fifo_vld),
    .out_ready(array_wr_ready),
    .out_data(fifo_out)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      array_addr <= ADDR_RST;
      array_read <= 1'b0;
      sleeping <= 1'b0;
      wr_stall <= 1'b0;
      array_wr_valid <= 1'b0;
      array_wr_addr <= ADDR_RST;
      array_wdata <= '0;
      array_wr_lanes <= LANE_NONE;
      dout_q <= '0;
      oe_n_q <= 1'b1;
    end else begin
      array_addr <= eff_addr;
      array_read <= rd_now;
      sleeping <= asleep;
      wr_stall <= stall_d;
      array_wr_valid <= fifo_vld && array_wr_ready;
      array_wr_addr <= fifo_out[FW-1 -: ADDR_W];
      array_wr_lanes <= fifo_out[DATA_W +: LANES];
      array_wdata <= fifo_out[DATA_W-1:0];
      dout_q <= array_rdata;
      oe_n_q <= !drive_d;
    end
  end

  // Output enable acts without clock sampling on the read path
  assign data_out = dout_q;
  assign data_oe_n = {DATA_W{oe_n_q || output_enable_n}};

  property p_proc_no_write;
    @(posedge ref_clk) disable iff (rst) proc_start |-> !wr_now;
  endproperty
  a_proc_no_write: assert property (p_proc_no_write) else $error("write taken with processor strobe");

  property p_proc_read;
    @(posedge ref_clk) disable iff (rst) proc_start && selected |=> cyc_q == CYC_READ;
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("no read start");

  property p_desel;
    @(posedge ref_clk) disable iff (rst)
      desel && !asleep |=> cyc_q == CYC_DESEL && data_oe_n == '1;
  endproperty
  a_desel: assert property (p_desel) else $error("no deselect");

  property p_sleep_float;
    @(posedge ref_clk) disable iff (rst) asleep |=> data_oe_n == '1 && sleeping;
  endproperty
  a_sleep_float: assert property (p_sleep_float) else $error("bus driven in sleep");

  property p_write_float;
    @(posedge ref_clk) disable iff (rst) wr_pend_q |-> data_oe_n == '1;
  endproperty
  a_write_float: assert property (p_write_float) else $error("bus driven on write");

  // Write start by controller strobe alone
  sequence s_ctrl_wr_start;
    ctrl_start && selected && wr_req;
  endsequence

  property p_ctrl_write;
    @(posedge ref_clk) disable iff (rst) s_ctrl_wr_start |=> cyc_q == CYC_WRITE;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("no write");

  property p_oe_gate;
    @(posedge ref_clk) disable iff (rst) output_enable_n |-> data_oe_n == '1;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("drive with enable high");

  property p_load_addr;
    @(posedge ref_clk) disable iff (rst) load |=> array_addr == $past(addr);
  endproperty
  a_load_addr: assert property (p_load_addr) else $error("address not captured");

  property p_global;
    @(posedge ref_clk) disable iff (rst) !all_bytes_write_n |-> lanes == LANE_ALL;
  endproperty
  a_global: assert property (p_global) else $error("global write lanes");
endmodule

// ---- sync_burst_sram_cycle_ctrl_tb.sv ----
// Self-checking testbench for the burst SRAM cycle controller
`timescale 1ns/1ns
module sync_burst_sram_cycle_ctrl_tb;
  logic ref_clk = 1'b0, rst = 1'b1, hold = 1'b0;
  logic pstb_n, cstb_n, step_n, sela_n, selh, selb_n, sleep, ord, oe_n, allw_n, lwe_n;
  logic [1:0] lsel_n, wl;
  logic [16:0] ad, a_addr, wa;
  logic [17:0] din, dout, doe_n, rdat, wd;
  logic a_rd, wv, wrdy, slpg, stall;
  int n_fail = 0;
  int num_checks = 0;
  always #25 ref_clk = ~ref_clk;
  sync_burst_sram_cycle_ctrl #(.FIFO_DEPTH_P(4)) sync_burst_sram_cycle_ctrl_i (
    .ref_clk(ref_clk), .rst(rst), .processor_addr_strobe_n(pstb_n),
    .controller_addr_strobe_n(cstb_n), .burst_advance_n(step_n), .chip_sel_low_a(sela_n),
    .chip_sel_high(selh), .chip_sel_low_b(selb_n), .sleep_request(sleep),
    .burst_order_sel(ord), .output_enable_n(oe_n), .all_bytes_write_n(allw_n),
    .lane_write_enable_n(lwe_n), .lane_select_n(lsel_n), .addr(ad), .data_in(din),
    .data_out(dout), .data_oe_n(doe_n), .array_addr(a_addr), .array_read(a_rd),
    .array_rdata(rdat), .array_wr_valid(wv), .array_wr_ready(wrdy), .array_wr_addr(wa),
    .array_wdata(wd), .array_wr_lanes(wl), .sleeping(slpg), .wr_stall(stall));
  sram_array_model sram_array_model_i (.ref_clk(ref_clk), .hold(hold), .rd_addr(a_addr),
    .rd_en(a_rd), .rdata(rdat), .wr_valid(wv), .wr_ready(wrdy), .wr_addr(wa), .wdata(wd),
    .wr_lanes(wl));
  task automatic chk(input logic [17:0] e, input logic [17:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #2;
  endtask
  // Deselect via first select high keeps any open burst from continuing
  task automatic idle();
    pstb_n = 1'b1; cstb_n = 1'b0; sela_n = 1'b1; selh = 1'b1; selb_n = 1'b0;
    step_n = 1'b1; allw_n = 1'b1; lwe_n = 1'b1; lsel_n = 2'h3; oe_n = 1'b1; sleep = 1'b0;
  endtask
  task automatic wait_log(input int n);
    for (int i = 0; i < 40 && sram_array_model_i.log_a.size() < n; i++) tick();
    if (sram_array_model_i.log_a.size() < n) begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic t_desel();
    idle(); oe_n = 1'b0;
    tick(); tick();
    chk(18'h0, {17'h0, a_rd});
    chk(18'h3FFFF, doe_n);
  endtask
  task automatic t_read(input logic [16:0] a, input logic o);
    logic [1:0] lo;
    ord = o; sela_n = 1'b0; pstb_n = 1'b0; cstb_n = 1'b1; ad = a; allw_n = 1'b0; oe_n = 1'b0;
    tick();
    chk(18'h1, {17'h0, a_rd});
    chk({1'b0, a}, {1'b0, a_addr});
    chk(18'h0, doe_n);
    oe_n = 1'b1;
    #1 chk(18'h3FFFF, doe_n);
    oe_n = 1'b0; pstb_n = 1'b1; sela_n = 1'b1; allw_n = 1'b1; ad = ~a; step_n = 1'b0;
    for (int k = 1; k < 4; k++) begin
      lo = o ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
      tick();
      chk({1'b0, a[16:2], lo}, {1'b0, a_addr});
      if (k == 1) chk({a, 1'b1}, dout);
    end
    step_n = 1'b1;
    tick();
    chk({1'b0, a[16:2], lo}, {1'b0, a_addr});
    chk(18'h0, 18'(sram_array_model_i.log_a.size()));
    idle(); tick();
  endtask
  task automatic t_write(input logic [16:0] a);
    // Output enable goes high ahead of the write start
    ord = 1'b0; sela_n = 1'b0; cstb_n = 1'b0; pstb_n = 1'b1; oe_n = 1'b1;
    allw_n = 1'b0; ad = a; din = 18'h2A5A5;
    tick();
    chk(18'h3FFFF, doe_n);
    oe_n = 1'b0; cstb_n = 1'b1; sela_n = 1'b1; allw_n = 1'b1; lwe_n = 1'b0;
    lsel_n = 2'h1; step_n = 1'b0; din = 18'h1C3C3;
    tick();
    chk(18'h3FFFF, doe_n);
    step_n = 1'b1; lsel_n = 2'h2; din = 18'h0F00F;
    tick();
    idle();
    wait_log(3);
    chk({1'b0, a}, {1'b0, sram_array_model_i.log_a[0]});
    chk(18'h2A5A5, sram_array_model_i.log_d[0]);
    chk(18'h3, {16'h0, sram_array_model_i.log_l[0]});
    chk({1'b0, a[16:2], a[1:0] + 2'h1}, {1'b0, sram_array_model_i.log_a[1]});
    chk(18'h1C3C3, sram_array_model_i.log_d[1]);
    chk(18'h2, {16'h0, sram_array_model_i.log_l[1]});
    chk({1'b0, a[16:2], a[1:0] + 2'h1}, {1'b0, sram_array_model_i.log_a[2]});
    chk(18'h0F00F, sram_array_model_i.log_d[2]);
    chk(18'h1, {16'h0, sram_array_model_i.log_l[2]});
    sram_array_model_i.log_a.delete(); sram_array_model_i.log_d.delete();
    sram_array_model_i.log_l.delete();
  endtask
  task automatic t_both();
    sela_n = 1'b0; pstb_n = 1'b0; cstb_n = 1'b0; allw_n = 1'b0; ad = 17'h0F0F3; oe_n = 1'b0;
    tick();
    chk(18'h1, {17'h0, a_rd});
    chk(18'h0F0F3, {1'b0, a_addr});
    idle(); tick(); tick(); tick();
    chk(18'h0, 18'(sram_array_model_i.log_a.size()));
    sela_n = 1'b1; pstb_n = 1'b0; cstb_n = 1'b1;
    tick();
    chk(18'h0, {17'h0, a_rd});
    idle(); tick();
  endtask
  task automatic t_sleep();
    sleep = 1'b1; sela_n = 1'b0; pstb_n = 1'b0; cstb_n = 1'b1; oe_n = 1'b0; ad = 17'h00155;
    tick(); tick();
    chk(18'h1, {17'h0, slpg});
    chk(18'h0, {17'h0, a_rd});
    chk(18'h3FFFF, doe_n);
    idle();
    for (int i = 0; i < 6 && slpg !== 1'b0; i++) tick();
    chk(18'h0, {17'h0, slpg});
  endtask
  task automatic t_fifo();
    logic seen;
    seen = 1'b0; hold = 1'b1; sela_n = 1'b0; cstb_n = 1'b0; pstb_n = 1'b1; allw_n = 1'b0;
    ad = 17'h1FFFC; din = 18'h0;
    for (int i = 0; i < 8; i++) begin
      tick();
      seen = seen | (stall === 1'b1);
      cstb_n = 1'b1; sela_n = 1'b1; din = din + 18'h1;
    end
    chk(18'h1, {17'h0, seen});
    idle(); hold = 1'b0;
    wait_log(4);
    for (int i = 0; i < 4; i++) begin
      chk(18'(i), sram_array_model_i.log_d[i]);
      chk(18'h1FFFC, {1'b0, sram_array_model_i.log_a[i]});
    end
  endtask
  initial begin
    idle(); ord = 1'b0; ad = 17'h0; din = 18'h0;
    repeat (2) @(posedge ref_clk);
    #2 rst = 1'b0;
    t_desel();
    t_read(17'h1ABC5, 1'b0);
    t_read(17'h00A46, 1'b1);
    t_write(17'h03217);
    t_both();
    t_sleep();
    t_fifo();
    final_report();
  end
endmodule
